// >>> rtl/pss_consts.svh
// constants for the power-up safety sequencer: timing, offsets, field positions
// assumes a 10 MHz core clock and a 32-bit classic wishbone register port
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

`define PSS_CLK_HZ 10000000
`define PSS_CHECK_MS 50
`define PSS_DONE_MS 100
`define PSS_GATE_OFF_MAX_US 500
`define PSS_CHECK_CYC (`PSS_CHECK_MS * (`PSS_CLK_HZ / 1000))
`define PSS_DONE_CYC (`PSS_DONE_MS * (`PSS_CLK_HZ / 1000))
`define PSS_GATE_OFF_MAX_CYC (`PSS_GATE_OFF_MAX_US * (`PSS_CLK_HZ / 1000000))
`define PSS_TIMER_W 20

`define PSS_ADR_W 8
`define PSS_CTRL_ADDR 8'h00
`define PSS_STAT_ADDR 8'h04
`define PSS_CTRL_RST 2'h3
`define PSS_CTRL_CHG_BIT 0
`define PSS_CTRL_DSG_BIT 1

`endif

// >>> rtl/pss_pkg.sv
// types shared by the power-up safety sequencer files
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package pss_pkg;
	// comparator outputs, used for both the raw and the filtered paths
	typedef struct packed {
		logic cell_undervoltage;
		logic cell_overvoltage;
		logic discharge_overcurrent;
		logic discharge_short;
	} pss_comp_s;

	typedef struct packed {
		logic supply_lockout_flag;
		logic charger_present_flag;
		logic undervolt_flag;
		logic overvolt_flag;
	} pss_flags_s;

	typedef enum logic [5:0] {
		ST_LOCKOUT = 6'h01,
		ST_WAIT = 6'h02,
		ST_RECOVER = 6'h04,
		ST_RUN = 6'h08,
		ST_PROTECT = 6'h10,
		ST_SHUTDOWN = 6'h20
	} pss_state_e;
endpackage : pss_pkg
`default_nettype wire

// >>> rtl/pss_interval_timer.sv
// free-running up counter that restarts from zero and saturates at its top
// assumes restart is a synchronous level from the sequencer
`default_nettype none
module pss_interval_timer #(
	parameter int WIDTH = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic restart_i,
	output logic [WIDTH-1:0] count_o
);
	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;

	always_comb begin
		count_nxt = count_r;
		if (restart_i) begin
			count_nxt = '0;
		end else if (count_r != {WIDTH{1'b1}}) begin
			count_nxt = count_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign count_o = count_r;
endmodule : pss_interval_timer
`default_nettype wire

// >>> rtl/pss_sequencer.sv
// power-up safety sequencer with gate shutoff and wishbone status port
// assumes all pin inputs synchronous to clk_i; raw_comp_i comes unfiltered, filtered_comp_i filtered
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`include "pss_consts.svh"
`default_nettype none
module pss_sequencer #(
	parameter int CHECK_CYCLES = `PSS_CHECK_CYC,
	parameter int DONE_CYCLES = `PSS_DONE_CYC,
	parameter int GATE_OFF_MAX_CYCLES = `PSS_GATE_OFF_MAX_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`PSS_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic above_startup_threshold_i,
	input wire logic supply_in_range_i,
	input wire logic charger_detect_i,
	input wire logic shutdown_request_i,
	input wire logic system_undervoltage_i,
	input wire logic charge_gate_reservoir_low_i,
	input wire logic discharge_gate_reservoir_low_i,
	input wire pss_pkg::pss_comp_s raw_comp_i,
	input wire pss_pkg::pss_comp_s filtered_comp_i,
	output logic charge_gate_drive_o,
	output logic discharge_gate_drive_o,
	output logic undervolt_hyst_select_o,
	output logic overvolt_hyst_select_o,
	output logic safety_check_pulse_o,
	output logic powerup_complete_o,
	output logic late_checks_enable_o,
	output logic regulator_enable_o,
	output logic fault_status_o,
	output pss_pkg::pss_comp_s protect_cause_o,
	output pss_pkg::pss_flags_s flags_o
);
	localparam int TW = `PSS_TIMER_W;
	// assertion window capped at 1000 cycles; the gates actually drop one cycle after a kill
	localparam int KILL_LIM = (GATE_OFF_MAX_CYCLES > 1000) ? 1000 : GATE_OFF_MAX_CYCLES;

	pss_pkg::pss_state_e state_r, state_nxt;
	logic reg_en_r, reg_en_nxt;
	logic pulse_r, pulse_nxt;
	logic done_r, done_nxt;
	logic fault_r, fault_nxt;
	pss_pkg::pss_comp_s cause_r, cause_nxt;
	pss_pkg::pss_flags_s flags_r, flags_nxt;
	logic chg_r, chg_nxt, dsg_r, dsg_nxt;
	logic uvh_r, uvh_nxt, ovh_r, ovh_nxt;
	logic [1:0] ctrl_r, ctrl_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	logic timer_restart;
	logic [TW-1:0] timer_cnt;
	logic in_seq;
	logic gate_kill;

	assign in_seq = (state_r == pss_pkg::ST_WAIT) || (state_r == pss_pkg::ST_RECOVER);
	assign timer_restart = !in_seq;

	pss_interval_timer #(
		.WIDTH(TW)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(timer_restart),
		.count_o(timer_cnt)
	);

	// immediate shutoff, well inside the allowed time
	assign gate_kill = charge_gate_reservoir_low_i || discharge_gate_reservoir_low_i ||
		system_undervoltage_i;

	// sequencer state
	always_comb begin
		state_nxt = state_r;
		reg_en_nxt = reg_en_r;
		pulse_nxt = 1'b0;
		done_nxt = done_r;
		fault_nxt = fault_r;
		cause_nxt = cause_r;
		case (state_r)
			pss_pkg::ST_LOCKOUT: begin
				// power-on reset state waits for threshold
				if (above_startup_threshold_i) begin
					reg_en_nxt = 1'b1;
					state_nxt = pss_pkg::ST_WAIT;
				end
			end
			pss_pkg::ST_WAIT: begin
				// single check pulse at 50 ms
				if (timer_cnt == TW'(CHECK_CYCLES - 1)) begin
					pulse_nxt = 1'b1;
					state_nxt = pss_pkg::ST_RECOVER;
				end
			end
			pss_pkg::ST_RECOVER: begin
				if (timer_cnt == TW'(DONE_CYCLES - 1)) begin
					done_nxt = 1'b1;
					state_nxt = fault_r ? pss_pkg::ST_PROTECT : pss_pkg::ST_RUN;
				end
			end
			pss_pkg::ST_RUN: begin
				if (filtered_comp_i != '0) begin
					cause_nxt = filtered_comp_i;
					state_nxt = pss_pkg::ST_PROTECT;
				end
			end
			pss_pkg::ST_PROTECT: begin
				// recovery is simplified: leave once all comparators clear
				if (filtered_comp_i == '0) begin
					fault_nxt = 1'b0;
					cause_nxt = '0;
					state_nxt = pss_pkg::ST_RUN;
				end
			end
			pss_pkg::ST_SHUTDOWN: begin
				// only a charger wakes it, then rerun the checks
				if (charger_detect_i) begin
					reg_en_nxt = 1'b1;
					state_nxt = pss_pkg::ST_WAIT;
				end
			end
			default: begin
				state_nxt = pss_pkg::ST_LOCKOUT;
				reg_en_nxt = 1'b0;
			end
		endcase
		// sticky fault from the check sample
		if (pulse_r && (raw_comp_i != '0)) begin
			fault_nxt = 1'b1;
			cause_nxt = raw_comp_i;
		end
		if (state_r != pss_pkg::ST_LOCKOUT && state_r != pss_pkg::ST_SHUTDOWN &&
				shutdown_request_i) begin
			state_nxt = pss_pkg::ST_SHUTDOWN;
			reg_en_nxt = 1'b0;
		end
		// leaving the operating range also drops the regulator and goes to lockout
		if (!supply_in_range_i) begin
			state_nxt = pss_pkg::ST_LOCKOUT;
			reg_en_nxt = 1'b0;
		end
		if (state_nxt == pss_pkg::ST_WAIT) begin
			done_nxt = 1'b0;
			fault_nxt = 1'b0;
			cause_nxt = '0;
		end
		if (state_nxt == pss_pkg::ST_LOCKOUT || state_nxt == pss_pkg::ST_SHUTDOWN) begin
			done_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= pss_pkg::ST_LOCKOUT;
			reg_en_r <= 1'b0;
			pulse_r <= 1'b0;
			done_r <= 1'b0;
			fault_r <= 1'b0;
			cause_r <= '0;
		end else begin
			state_r <= state_nxt;
			reg_en_r <= reg_en_nxt;
			pulse_r <= pulse_nxt;
			done_r <= done_nxt;
			fault_r <= fault_nxt;
			cause_r <= cause_nxt;
		end
	end

	// gate drives, hysteresis selects and flags
	always_comb begin
		chg_nxt = 1'b0;
		dsg_nxt = 1'b0;
		uvh_nxt = 1'b1;
		ovh_nxt = 1'b1;
		flags_nxt.supply_lockout_flag = !above_startup_threshold_i;
		flags_nxt.charger_present_flag = charger_detect_i;
		flags_nxt.undervolt_flag = flags_r.undervolt_flag;
		flags_nxt.overvolt_flag = flags_r.overvolt_flag;
		// set on detection, cleared once the comparator recovers
		if (pulse_r) begin
			flags_nxt.undervolt_flag = raw_comp_i.cell_undervoltage;
			flags_nxt.overvolt_flag = raw_comp_i.cell_overvoltage;
		end else if (done_r) begin
			flags_nxt.undervolt_flag = filtered_comp_i.cell_undervoltage;
			flags_nxt.overvolt_flag = filtered_comp_i.cell_overvoltage;
		end
		// normal-mode values once complete with the regulator on, fault or not
		if (done_r && reg_en_r) begin
			uvh_nxt = flags_r.undervolt_flag;
			ovh_nxt = flags_r.overvolt_flag;
			if (state_r == pss_pkg::ST_RUN) begin
				chg_nxt = ctrl_r[`PSS_CTRL_CHG_BIT];
				dsg_nxt = ctrl_r[`PSS_CTRL_DSG_BIT];
			end else if (state_r == pss_pkg::ST_PROTECT && cause_r.cell_overvoltage &&
					!cause_r.cell_undervoltage && !cause_r.discharge_overcurrent &&
					!cause_r.discharge_short) begin
				// overvoltage alone keeps discharge available
				dsg_nxt = ctrl_r[`PSS_CTRL_DSG_BIT];
			end
		end
		if (!done_r || gate_kill) begin
			chg_nxt = 1'b0;
			dsg_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chg_r <= 1'b0;
			dsg_r <= 1'b0;
			uvh_r <= 1'b1;
			ovh_r <= 1'b1;
			flags_r <= '0;
		end else begin
			chg_r <= chg_nxt;
			dsg_r <= dsg_nxt;
			uvh_r <= uvh_nxt;
			ovh_r <= ovh_nxt;
			flags_r <= flags_nxt;
		end
	end

	// wishbone slave, one wait state, unmapped reads return zero
	always_comb begin
		ctrl_nxt = ctrl_r;
		ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
		rdat_nxt = rdat_r;
		if (ack_nxt) begin
			rdat_nxt = '0;
			if (wb_we_i && wb_sel_i[0] && wb_adr_i == `PSS_CTRL_ADDR) begin
				ctrl_nxt = wb_dat_i[1:0];
			end
			if (!wb_we_i && wb_adr_i == `PSS_CTRL_ADDR) begin
				rdat_nxt = {30'h0, ctrl_r};
			end else if (!wb_we_i && wb_adr_i == `PSS_STAT_ADDR) begin
				rdat_nxt = {15'h0, reg_en_r, flags_r, cause_r, fault_r, done_r, state_r};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= `PSS_CTRL_RST;
			ack_r <= 1'b0;
			rdat_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	assign wb_dat_o = rdat_r;
	assign wb_ack_o = ack_r;
	assign charge_gate_drive_o = chg_r;
	assign discharge_gate_drive_o = dsg_r;
	assign undervolt_hyst_select_o = uvh_r;
	assign overvolt_hyst_select_o = ovh_r;
	assign safety_check_pulse_o = pulse_r;
	assign powerup_complete_o = done_r;
	assign late_checks_enable_o = done_r;
	assign regulator_enable_o = reg_en_r;
	assign fault_status_o = fault_r;
	assign protect_cause_o = cause_r;
	assign flags_o = flags_r;

	a_gates_low_early: assert property (@(posedge clk_i) disable iff (rst_i)
		!done_r |=> !chg_r && !dsg_r) else $error("gate driven before completion");
	a_undervolt_hyst_select_forced: assert property (@(posedge clk_i) disable iff (rst_i)
		!done_r |=> uvh_r) else $error("uv hysteresis select not forced");
	a_overvolt_hyst_select_forced: assert property (@(posedge clk_i) disable iff (rst_i)
		!done_r |=> ovh_r) else $error("ov hysteresis select not forced");
	a_check_pulse_time: assert property (@(posedge clk_i) disable iff (rst_i)
		pulse_r |-> timer_cnt == TW'(CHECK_CYCLES) && !$past(pulse_r))
		else $error("check pulse at wrong time");
	a_fault_captured: assert property (@(posedge clk_i) disable iff (rst_i)
		pulse_r && raw_comp_i != '0 && supply_in_range_i && !shutdown_request_i |=> fault_r)
		else $error("sampled fault not latched");
	a_done_time: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(done_r) |-> $past(timer_cnt) == TW'(DONE_CYCLES - 1))
		else $error("completion at wrong time");
	a_fault_protects: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(done_r) && $past(fault_r) |-> state_r == pss_pkg::ST_PROTECT)
		else $error("fault did not enter protection");
	a_shutdown_exit: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == pss_pkg::ST_SHUTDOWN && !charger_detect_i && supply_in_range_i
		|=> state_r == pss_pkg::ST_SHUTDOWN) else $error("shutdown left without charger");
	a_gate_kill: assert property (@(posedge clk_i) disable iff (rst_i)
		gate_kill |-> ##[1:KILL_LIM] (!chg_r && !dsg_r))
		else $error("gates not disabled in time");
	a_reg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_en_r && supply_in_range_i && !shutdown_request_i |=> reg_en_r)
		else $error("regulator dropped while in range");
endmodule : pss_sequencer
`default_nettype wire

// >>> tb/pss_far_side.sv
// far-side model: cells, supply and charger seen by the sequencer
// assumes the bench sets its knobs by non-blocking assignment after a rising edge
`default_nettype none
module pss_far_side (
	input wire logic power_on_i,
	input wire logic sag_i,
	input wire logic charger_on_i,
	input wire pss_pkg::pss_comp_s cell_fault_i,
	output logic above_startup_threshold_o,
	output logic supply_in_range_o,
	output logic charger_detect_o,
	output pss_pkg::pss_comp_s raw_comp_o,
	output pss_pkg::pss_comp_s filtered_comp_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// a sag leaves the pack in range but under the startup level
	assign above_startup_threshold_o = power_on_i & ~sag_i;
	assign supply_in_range_o = power_on_i;
	assign charger_detect_o = charger_on_i;
	// no filter delay modelled: a fault shows on both paths at once
	assign raw_comp_o = cell_fault_i;
	assign filtered_comp_o = cell_fault_i;
endmodule : pss_far_side
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the power-up safety sequencer
// assumes short check and done counts so a whole run takes a few hundred cycles
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CHK = 20;
	localparam int DONE = 40;
	logic clk_i, rst_i, cyc, stb, we, ack, sag, chg_on, sd_req, sys_uv, cres, dres, pwr;
	logic charge_gate_drive, discharge_gate_drive, uvh, ovh, pulse, done, late, reg_en, fault;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_w, dat_r, rd;
	logic ast, sir, cdet;
	pss_pkg::pss_comp_s cmd, raw, filt, cause;
	pss_pkg::pss_flags_s flags;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;

	pss_far_side far (.power_on_i(pwr), .sag_i(sag), .charger_on_i(chg_on),
		.cell_fault_i(cmd), .above_startup_threshold_o(ast), .supply_in_range_o(sir),
		.charger_detect_o(cdet), .raw_comp_o(raw), .filtered_comp_o(filt));

	pss_sequencer #(.CHECK_CYCLES(CHK), .DONE_CYCLES(DONE), .GATE_OFF_MAX_CYCLES(4)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.above_startup_threshold_i(ast), .supply_in_range_i(sir), .charger_detect_i(cdet),
		.shutdown_request_i(sd_req), .system_undervoltage_i(sys_uv),
		.charge_gate_reservoir_low_i(cres), .discharge_gate_reservoir_low_i(dres),
		.raw_comp_i(raw), .filtered_comp_i(filt), .charge_gate_drive_o(charge_gate_drive),
		.discharge_gate_drive_o(discharge_gate_drive), .undervolt_hyst_select_o(uvh),
		.overvolt_hyst_select_o(ovh), .safety_check_pulse_o(pulse),
		.powerup_complete_o(done), .late_checks_enable_o(late), .regulator_enable_o(reg_en),
		.fault_status_o(fault), .protect_cause_o(cause), .flags_o(flags));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failures++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	// one classic cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		sel <= s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1)
			chk("wb_ack", 1, 0);
	endtask : wb

	task automatic powerup();
		int n, p;
		logic held;
		n = 0;
		p = -1;
		held = 1'b1;
		while (reg_en !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		n = 0;
		while (done !== 1'b1 && n < 100) begin
			if (charge_gate_drive !== 1'b0 || discharge_gate_drive !== 1'b0 || uvh !== 1'b1 || ovh !== 1'b1 || late !== 1'b0)
				held = 1'b0;
			tick(1);
			n++;
			if (pulse === 1'b1)
				p = n;
		end
		chk("check_pulse_at", CHK, p);
		chk("complete_at", DONE, n);
		chk("forced_outputs", 1, held);
	endtask : powerup

	task automatic t_reset();
		tick(30);
		chk("reg_in_lockout", 0, reg_en);
		chk("gates_rst", 0, {charge_gate_drive, discharge_gate_drive});
		chk("hyst_rst", 2'b11, {uvh, ovh});
		wb(0, 8'h00, 0, 4'hf, rd);
		chk("ctrl_rst", 32'h3, rd);
		wb(0, 8'h04, 0, 4'hf, rd);
		chk("status_rst", 32'h8001, rd);
		wb(0, 8'h08, 0, 4'hf, rd);
		chk("unmapped", 0, rd);
	endtask : t_reset

	task automatic t_normal();
		@(posedge clk_i);
		sag <= 1'b0;
		powerup();
		tick(1);
		chk("gates_run", 2'b11, {charge_gate_drive, discharge_gate_drive});
		chk("hyst_run", 2'b00, {uvh, ovh});
		chk("late_checks", 1, late);
		wb(0, 8'h04, 0, 4'hf, rd);
		chk("status_run", 32'h10048, rd);
		@(posedge clk_i);
		sag <= 1'b1;
		tick(5);
		chk("reg_after_sag", 1, reg_en);
	endtask : t_normal

	task automatic t_bus();
		wb(1, 8'h00, 32'h1, 4'h1, rd);
		tick(2);
		chk("gates_ctrl1", 2'b10, {charge_gate_drive, discharge_gate_drive});
		wb(1, 8'h00, 32'h0, 4'h0, rd);
		wb(1, 8'h08, 32'h0, 4'hf, rd);
		wb(0, 8'h00, 0, 4'hf, rd);
		chk("ctrl_kept", 32'h1, rd);
		wb(1, 8'h00, 32'h3, 4'h1, rd);
	endtask : t_bus

	task automatic t_gate_kill();
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_i);
			sys_uv <= (k == 0);
			cres <= (k == 1);
			dres <= (k == 2);
			tick(1);
			chk("gates_killed", 0, {charge_gate_drive, discharge_gate_drive});
			@(posedge clk_i);
			{sys_uv, cres, dres} <= 3'b000;
			tick(2);
			chk("gates_back", 2'b11, {charge_gate_drive, discharge_gate_drive});
		end
	endtask : t_gate_kill

	task automatic t_shutdown();
		@(posedge clk_i);
		sd_req <= 1'b1;
		tick(2);
		chk("sd_reg_done", 0, {reg_en, done, charge_gate_drive, discharge_gate_drive});
		@(posedge clk_i);
		sd_req <= 1'b0;
		tick(10);
		chk("sd_stays", 0, reg_en);
		@(posedge clk_i);
		chg_on <= 1'b1;
		powerup();
		tick(1);
		chk("charger_flag", 1, flags.charger_present_flag);
		@(posedge clk_i);
		chg_on <= 1'b0;
	endtask : t_shutdown

	task automatic t_fault();
		@(posedge clk_i);
		rst_i <= 1'b1;
		cmd <= 4'b0100;
		sag <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		powerup();
		tick(1);
		chk("fault_bit", 1, fault);
		chk("cause", 4'b0100, cause);
		chk("gates_ov", 2'b01, {charge_gate_drive, discharge_gate_drive});
		chk("ov_flag", 1, flags.overvolt_flag);
		wb(0, 8'h04, 0, 4'hf, rd);
		chk("state_protect", 8'hd0, rd[7:0]);
		@(posedge clk_i);
		cmd <= 4'b0000;
		tick(3);
		chk("gates_recover", 2'b11, {charge_gate_drive, discharge_gate_drive});
	endtask : t_fault

	// supply leaves the operating range, then returns and reruns the sequence
	task automatic t_power_loss();
		@(posedge clk_i);
		pwr <= 1'b0;
		tick(2);
		chk("reg_out_of_range", 0, {reg_en, done, charge_gate_drive, discharge_gate_drive});
		@(posedge clk_i);
		pwr <= 1'b1;
		powerup();
	endtask : t_power_loss

	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, sag, chg_on, sd_req, sys_uv, cres, dres} = 9'h020;
		pwr = 1'b1;
		{adr, sel, dat_w} = 44'h0;
		cmd = 4'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_normal();
		t_bus();
		t_gate_kill();
		t_shutdown();
		t_fault();
		t_power_loss();
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
